// File: pkg/pmc_pkg.sv
// constants and types for the power mode controller
`default_nettype none

package pmc_pkg;

   // register bus
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   // register numbers
   localparam logic [4:0] REG_BASIC = 5'h00;
   localparam logic [4:0] REG_DIGCTL = 5'h10;
   localparam logic [4:0] REG_AFECTL = 5'h11;
   localparam logic [4:0] REG_EXPCTL = 5'h18;
   localparam logic [4:0] REG_PSTAT = 5'h19;
   localparam logic [4:0] REG_PXCTL = 5'h1a;
   localparam logic [4:0] REG_PHYCTL2 = 5'h1f;

   // field positions
   localparam int BIT_SRESET = 15;
   localparam int BIT_ANEG = 12;
   localparam int BIT_PDOWN = 11;
   localparam int BIT_PLL_AUTO_OFF = 4;
   localparam int BIT_SLOW_OSC = 5;
   localparam int BIT_SLEEP_DIS = 11;
   localparam int BIT_SAVE_EN = 10;
   localparam int BIT_LONG_GAP = 0;
   localparam int BIT_ST_MODE = 0;
   localparam int BIT_ST_LINK = 3;
   localparam int BIT_ST_ENERGY = 4;

   // values after reset
   localparam logic RST_PDOWN = 1'h0;
   localparam logic RST_ANEG = 1'h0;
   localparam logic RST_SAVE_EN = 1'h0;
   localparam logic RST_SLEEP_DIS = 1'h1;
   localparam logic RST_PLL_AUTO_OFF = 1'h0;
   localparam logic RST_SLOW_OSC = 1'h0;
   localparam logic RST_LONG_GAP = 1'h0;

   // timing
   localparam int CLK_KHZ = 40000;
   localparam int PULSE_GAP_MS = 16;
   localparam int LONG_GAP_MS = 64;
   localparam int PULSE_GAP_CYC = PULSE_GAP_MS * CLK_KHZ;
   localparam int LONG_GAP_CYC = LONG_GAP_MS * CLK_KHZ;
   localparam int GAP_W = 24;
   localparam int CORE_RST_NS = 400;
   localparam int CORE_RST_CYC = (CORE_RST_NS * CLK_KHZ + 999999) / 1000000;
   localparam int RST_CNT_W = 5;

   // operating modes
   typedef enum logic [2:0] {
      PMC_NORMAL = 3'h0,
      PMC_SAVE = 3'h1,
      PMC_SLEEP = 3'h2,
      PMC_SLEEP_NOPLL = 3'h3,
      PMC_PWRDN = 3'h4,
      PMC_DEEP = 3'h5,
      PMC_RESET = 3'h6
   } pmc_mode_t;

endpackage

`default_nettype wire

// File: logic/pmc_sync3.sv
// three-stage synchroniser with agreement filter
`default_nettype none

module pmc_sync3 (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // data
   input wire logic d_in,
   output logic q_out
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } pmc_sync_t;

   pmc_sync_t q, d;

   always_comb begin
      d = q;
      d.s1 = d_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // only the later two stages decide; first stage may be metastable
      if (q.s2 == q.s3) begin
         d.q = q.s3;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign q_out = q.q;

endmodule

`default_nettype wire

// File: logic/pmc_power_ctrl.sv
// power mode controller: mode registers, mode selection and block enables
//
// Contract
// - power saving armed by 1Fh bit 10
// - power saving keeps transmitter, energy detect, PLL
// - power saving off after power-up
// - sleep armed when 18h bit 11 is zero
// - 10h bit 4 stops PLL during sleep
// - sleep keeps sending periodic link pulses
// - sleep disabled after power-up
// - basic control bit 11 enters power-down
// - power-down keeps only management interface alive
// - clearing bit 11 leaves power-down
// - 11h bit 5 selects slow oscillator
// - slow oscillator plus power-down is lowest state
// - basic control bit 15 resets, self-clears
// - reset in power-down needs two writes
// - bit 12 enables autonegotiation, qualifies low modes
`default_nettype none

module pmc_power_ctrl #(
   parameter int PULSE_GAP_CYCLES = pmc_pkg::PULSE_GAP_CYC,
   parameter int LONG_GAP_CYCLES = pmc_pkg::LONG_GAP_CYC
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   // register port
   input wire logic [4:0] ADDR_IN,
   input wire logic [15:0] WR_DATA_IN,
   input wire logic WR_STB_IN,
   input wire logic RD_STB_IN,
   output logic [15:0] RD_DATA_OUT,
   // line and strap inputs, asynchronous
   input wire logic LINK_UP_IN,
   input wire logic ENERGY_IN,
   input wire logic ANEG_STRAP_IN,
   // block controls
   output logic RX_BLOCKS_EN_OUT,
   output logic TX_EN_OUT,
   output logic ENERGY_DET_EN_OUT,
   output logic PLL_EN_OUT,
   output logic SLOW_OSC_SEL_OUT,
   output logic CORE_RESET_OUT,
   output logic LINK_PULSE_OUT,
   output logic [2:0] MODE_OUT
);

   typedef struct packed {
      pmc_pkg::pmc_mode_t mode;
      logic [pmc_pkg::RST_CNT_W-1:0] rst_cnt;
      logic [pmc_pkg::GAP_W-1:0] gap_cnt;
      logic sreset;
      logic aneg;
      logic pdown;
      logic pll_auto_off;
      logic slow_osc;
      logic sleep_dis;
      logic save_en;
      logic long_gap;
      logic rx_en;
      logic tx_en;
      logic ed_en;
      logic pll_en;
      logic slow_sel;
      logic core_rst;
      logic pulse;
      logic [15:0] rd_data;
   } pmc_state_t;

   localparam logic [pmc_pkg::GAP_W-1:0] GAP_SHORT = pmc_pkg::GAP_W'(PULSE_GAP_CYCLES - 1);
   localparam logic [pmc_pkg::GAP_W-1:0] GAP_LONG = pmc_pkg::GAP_W'(LONG_GAP_CYCLES - 1);
   localparam logic [pmc_pkg::RST_CNT_W-1:0] RST_LAST = pmc_pkg::RST_CNT_W'(pmc_pkg::CORE_RST_CYC - 1);

   // block enable codes, ordered {rx blocks, transmitter, energy detect, pll}
   localparam logic [3:0] EN_ALL = 4'hf;
   localparam logic [3:0] EN_KEEP_PLL = 4'h7;
   localparam logic [3:0] EN_NO_PLL = 4'h6;
   localparam logic [3:0] EN_NONE = 4'h0;

   // everything to its default, core held in reset; strap caught at release
   function automatic pmc_state_t reset_state();
      pmc_state_t s;
      s = '0;
      s.mode = pmc_pkg::PMC_RESET;
      s.sreset = 1'h1;
      s.aneg = pmc_pkg::RST_ANEG;
      s.pdown = pmc_pkg::RST_PDOWN;
      s.pll_auto_off = pmc_pkg::RST_PLL_AUTO_OFF;
      s.slow_osc = pmc_pkg::RST_SLOW_OSC;
      s.sleep_dis = pmc_pkg::RST_SLEEP_DIS;
      s.save_en = pmc_pkg::RST_SAVE_EN;
      s.long_gap = pmc_pkg::RST_LONG_GAP;
      s.core_rst = 1'h1;
      return s;
   endfunction

   // mode wanted by the current settings and line state
   function automatic pmc_pkg::pmc_mode_t pick_mode(input pmc_state_t s, input logic link,
                                                    input logic energy);
      logic idle_line;
      idle_line = s.aneg && !link && !energy;
      // power-down is tested first so it outranks the line-driven modes
      if (s.pdown && s.slow_osc) begin
         pick_mode = pmc_pkg::PMC_DEEP;
      end else if (s.pdown) begin
         pick_mode = pmc_pkg::PMC_PWRDN;
      end else if (idle_line && !s.sleep_dis) begin
         if (s.pll_auto_off) begin
            pick_mode = pmc_pkg::PMC_SLEEP_NOPLL;
         end else begin
            pick_mode = pmc_pkg::PMC_SLEEP;
         end
      end else if (idle_line && s.save_en) begin
         pick_mode = pmc_pkg::PMC_SAVE;
      end else begin
         pick_mode = pmc_pkg::PMC_NORMAL;
      end
   endfunction

   // block enables per mode: {rx blocks, transmitter, energy detect, pll}
   function automatic logic [3:0] blocks_for(input pmc_pkg::pmc_mode_t m);
      case (m)
         pmc_pkg::PMC_NORMAL: begin
            blocks_for = EN_ALL;
         end
         pmc_pkg::PMC_SAVE: begin
            blocks_for = EN_KEEP_PLL;
         end
         pmc_pkg::PMC_SLEEP: begin
            blocks_for = EN_KEEP_PLL;
         end
         pmc_pkg::PMC_SLEEP_NOPLL: begin
            blocks_for = EN_NO_PLL;
         end
         pmc_pkg::PMC_PWRDN: begin
            blocks_for = EN_NONE;
         end
         pmc_pkg::PMC_DEEP: begin
            blocks_for = EN_NONE;
         end
         pmc_pkg::PMC_RESET: begin
            // core reset holds every block off
            blocks_for = EN_NONE;
         end
         default: begin
            blocks_for = EN_NONE;
         end
      endcase
   endfunction

   function automatic logic is_sleep(input pmc_pkg::pmc_mode_t m);
      is_sleep = (m == pmc_pkg::PMC_SLEEP) || (m == pmc_pkg::PMC_SLEEP_NOPLL);
   endfunction

   pmc_state_t q, d;
   logic [2:0] pin_raw;
   logic [2:0] pin_sync;
   logic link_s;
   logic energy_s;
   logic strap_s;
   logic [3:0] blocks;
   logic [15:0] rd_word;
   logic [pmc_pkg::GAP_W-1:0] gap_last;

   assign pin_raw = {ANEG_STRAP_IN, ENERGY_IN, LINK_UP_IN};

   // link, energy and strap come from pins, not from this clock
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         pmc_sync3 u_sync (
            .clk_in(REF_CLK_IN),
            .rst_in(RESET_IN),
            .d_in(pin_raw[gi]),
            .q_out(pin_sync[gi])
         );
      end
   endgenerate

   assign link_s = pin_sync[0];
   assign energy_s = pin_sync[1];
   assign strap_s = pin_sync[2];

   // read view of the registers; unmapped numbers read zero
   // served during core reset too, so software can poll the reset bit
   always_comb begin
      rd_word = 16'h0000;
      case (ADDR_IN)
         pmc_pkg::REG_BASIC: begin
            rd_word[pmc_pkg::BIT_SRESET] = q.sreset;
            rd_word[pmc_pkg::BIT_ANEG] = q.aneg;
            rd_word[pmc_pkg::BIT_PDOWN] = q.pdown;
         end
         pmc_pkg::REG_DIGCTL: begin
            rd_word[pmc_pkg::BIT_PLL_AUTO_OFF] = q.pll_auto_off;
         end
         pmc_pkg::REG_AFECTL: begin
            rd_word[pmc_pkg::BIT_SLOW_OSC] = q.slow_osc;
         end
         pmc_pkg::REG_EXPCTL: begin
            rd_word[pmc_pkg::BIT_SLEEP_DIS] = q.sleep_dis;
         end
         pmc_pkg::REG_PSTAT: begin
            rd_word[pmc_pkg::BIT_ST_MODE +: 3] = q.mode;
            rd_word[pmc_pkg::BIT_ST_LINK] = link_s;
            rd_word[pmc_pkg::BIT_ST_ENERGY] = energy_s;
         end
         pmc_pkg::REG_PXCTL: begin
            rd_word[pmc_pkg::BIT_LONG_GAP] = q.long_gap;
         end
         pmc_pkg::REG_PHYCTL2: begin
            rd_word[pmc_pkg::BIT_SAVE_EN] = q.save_en;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   assign gap_last = q.long_gap ? GAP_LONG : GAP_SHORT;

   always_comb begin
      d = q;
      d.pulse = 1'h0;
      d.rd_data = 16'h0000;

      // read data stand for exactly one cycle
      if (RD_STB_IN) begin
         d.rd_data = rd_word;
      end

      // writes are ignored while the core is held in reset
      if (WR_STB_IN && q.mode != pmc_pkg::PMC_RESET) begin
         case (ADDR_IN)
            pmc_pkg::REG_BASIC: begin
               if (WR_DATA_IN[pmc_pkg::BIT_SRESET] && q.pdown) begin
                  // first reset write only leaves power-down
                  d.pdown = 1'h0;
               end else if (WR_DATA_IN[pmc_pkg::BIT_SRESET]) begin
                  d = reset_state();
               end else begin
                  d.aneg = WR_DATA_IN[pmc_pkg::BIT_ANEG];
                  d.pdown = WR_DATA_IN[pmc_pkg::BIT_PDOWN];
               end
            end
            pmc_pkg::REG_DIGCTL: begin
               d.pll_auto_off = WR_DATA_IN[pmc_pkg::BIT_PLL_AUTO_OFF];
            end
            pmc_pkg::REG_AFECTL: begin
               d.slow_osc = WR_DATA_IN[pmc_pkg::BIT_SLOW_OSC];
            end
            pmc_pkg::REG_EXPCTL: begin
               d.sleep_dis = WR_DATA_IN[pmc_pkg::BIT_SLEEP_DIS];
            end
            pmc_pkg::REG_PSTAT: begin
               // status is read only; writes fall away
               d.rd_data = d.rd_data;
            end
            pmc_pkg::REG_PXCTL: begin
               d.long_gap = WR_DATA_IN[pmc_pkg::BIT_LONG_GAP];
            end
            pmc_pkg::REG_PHYCTL2: begin
               d.save_en = WR_DATA_IN[pmc_pkg::BIT_SAVE_EN];
            end
            default: begin
               d.rd_data = d.rd_data;
            end
         endcase
      end

      // mode sequencing
      case (q.mode)
         pmc_pkg::PMC_RESET: begin
            if (q.rst_cnt == RST_LAST) begin
               // strap level re-caught at the end of every core reset
               // the strap pin must settle four cycles before this edge
               d.aneg = strap_s;
               d.sreset = 1'h0;
               d.rst_cnt = '0;
               d.mode = pmc_pkg::PMC_NORMAL;
            end else begin
               d.rst_cnt = q.rst_cnt + 1'h1;
            end
         end
         default: begin
            if (d.mode != pmc_pkg::PMC_RESET) begin
               d.mode = pick_mode(d, link_s, energy_s);
            end
         end
      endcase

      // periodic link pulses while asleep, so two sleeping ends can wake
      // any exit clears the count, so the next sleep waits a full gap
      if (is_sleep(q.mode) && is_sleep(d.mode)) begin
         if (q.gap_cnt >= gap_last) begin
            d.gap_cnt = '0;
            d.pulse = 1'h1;
         end else begin
            d.gap_cnt = q.gap_cnt + 1'h1;
         end
      end else begin
         d.gap_cnt = '0;
      end

      // outputs follow the next mode so they change with it
      blocks = blocks_for(d.mode);
      d.rx_en = blocks[3];
      d.tx_en = blocks[2];
      d.ed_en = blocks[1];
      d.pll_en = blocks[0];
      // oscillator choice follows 11h bit 5 in every mode, power-down included, so the order of exit writes matters
      // the select only asks for the switch; this logic assumes its clock keeps running
      d.slow_sel = d.slow_osc;
      d.core_rst = (d.mode == pmc_pkg::PMC_RESET);
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         q <= reset_state();
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign RD_DATA_OUT = q.rd_data;
   assign RX_BLOCKS_EN_OUT = q.rx_en;
   assign TX_EN_OUT = q.tx_en;
   assign ENERGY_DET_EN_OUT = q.ed_en;
   assign PLL_EN_OUT = q.pll_en;
   assign SLOW_OSC_SEL_OUT = q.slow_sel;
   assign CORE_RESET_OUT = q.core_rst;
   assign LINK_PULSE_OUT = q.pulse;
   assign MODE_OUT = q.mode;

endmodule

`default_nettype wire

// File: testbench/pmc_checker.sv
// port assertions for the power mode controller
`default_nettype none

module pmc_checker (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   // register writes
   input wire logic [4:0] ADDR_IN,
   input wire logic [15:0] WR_DATA_IN,
   input wire logic WR_STB_IN,
   // block controls
   input wire logic RX_BLOCKS_EN_OUT,
   input wire logic TX_EN_OUT,
   input wire logic ENERGY_DET_EN_OUT,
   input wire logic PLL_EN_OUT,
   input wire logic SLOW_OSC_SEL_OUT,
   input wire logic CORE_RESET_OUT,
   input wire logic LINK_PULSE_OUT,
   input wire logic [2:0] MODE_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   logic [3:0] en;
   assign en = {RX_BLOCKS_EN_OUT, TX_EN_OUT, ENERGY_DET_EN_OUT, PLL_EN_OUT};
   AST_NORMAL_ON: assert property (MODE_OUT == 3'h0 |-> en == 4'hf)
      else $error("normal mode not fully powered");
   AST_SAVE_KEEP: assert property (MODE_OUT == 3'h1 |-> en == 4'h7)
      else $error("power saving enables wrong");
   AST_SLEEP_KEEP: assert property (MODE_OUT == 3'h2 |-> en == 4'h7)
      else $error("sleep enables wrong");
   AST_PLL_STOP: assert property (MODE_OUT == 3'h3 |-> en == 4'h6)
      else $error("sleep without pll enables wrong");
   AST_PWRDN_OFF: assert property (MODE_OUT inside {3'h4, 3'h5} |-> en == 4'h0)
      else $error("power-down left a block on");
   AST_DEEP_OSC: assert property (MODE_OUT == 3'h5 |-> SLOW_OSC_SEL_OUT)
      else $error("deep mode without slow oscillator");
   AST_PD_WRITE: assert property (WR_STB_IN && ADDR_IN == 5'h00 && WR_DATA_IN[11] && !WR_DATA_IN[15]
      && MODE_OUT != 3'h6 |=> MODE_OUT inside {3'h4, 3'h5}) else $error("power-down write ignored");
   AST_PULSE: assert property (LINK_PULSE_OUT |-> MODE_OUT inside {3'h2, 3'h3} ##1 !LINK_PULSE_OUT)
      else $error("link pulse outside sleep or too long");
   AST_SRESET: assert property ($rose(CORE_RESET_OUT) |-> ##[1:20] !CORE_RESET_OUT)
      else $error("core reset did not end");
   cover property (MODE_OUT == 3'h5);
   cover property (LINK_PULSE_OUT);
   cover property ($rose(CORE_RESET_OUT));
endmodule

bind pmc_power_ctrl pmc_checker i_chk (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
   .WR_DATA_IN(WR_DATA_IN), .WR_STB_IN(WR_STB_IN), .RX_BLOCKS_EN_OUT(RX_BLOCKS_EN_OUT), .TX_EN_OUT(TX_EN_OUT),
   .ENERGY_DET_EN_OUT(ENERGY_DET_EN_OUT), .PLL_EN_OUT(PLL_EN_OUT), .SLOW_OSC_SEL_OUT(SLOW_OSC_SEL_OUT),
   .CORE_RESET_OUT(CORE_RESET_OUT), .LINK_PULSE_OUT(LINK_PULSE_OUT), .MODE_OUT(MODE_OUT));

`default_nettype wire

// File: testbench/pmc_station.sv
// management station model driving the register port
`default_nettype none

module pmc_station (
   // clock
   input wire logic clk_in,
   // register port
   output logic [4:0] addr_out,
   output logic [15:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire logic [15:0] rdata_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      addr_out = 5'h00;
      wdata_out = 16'h0000;
      wr_out = 1'h0;
      rd_out = 1'h0;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'h1;
      @(posedge clk_in);
      wr_out <= 1'h0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'h1;
      @(posedge clk_in);
      rd_out <= 1'h0;
      #1;
      d = rdata_in;
   endtask
endmodule

`default_nettype wire

// File: testbench/phy_power_mode_control_test.sv
// self-checking bench for the power mode controller
`default_nettype none

module phy_power_mode_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic link = 1'h0;
   logic energy = 1'h0;
   logic strap = 1'h1;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, got;
   logic wr, rd, rx, tx, ed, pll, slow, core_rst, pulse;
   logic [2:0] mode;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   always #12.5 clk = ~clk;
   pmc_station i_st (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
   // short gaps keep the pulse scenarios brief
   pmc_power_ctrl #(.PULSE_GAP_CYCLES(20), .LONG_GAP_CYCLES(50)) i_dut (.REF_CLK_IN(clk), .RESET_IN(rst),
      .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_STB_IN(wr), .RD_STB_IN(rd), .RD_DATA_OUT(rdata), .LINK_UP_IN(link),
      .ENERGY_IN(energy), .ANEG_STRAP_IN(strap), .RX_BLOCKS_EN_OUT(rx), .TX_EN_OUT(tx), .ENERGY_DET_EN_OUT(ed),
      .PLL_EN_OUT(pll), .SLOW_OSC_SEL_OUT(slow), .CORE_RESET_OUT(core_rst), .LINK_PULSE_OUT(pulse), .MODE_OUT(mode));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         complete_run();
      end
   end
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic mchk(input pmc_pkg::pmc_mode_t e);
      chk({13'h0, mode}, {13'h0, e});
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      i_st.rd(a, got);
      chk(got, e);
   endtask
   // cycles from one link pulse to the next
   task automatic gap(output int k);
      k = 0;
      while (pulse !== 1'h1 && k < 200) begin
         idle(1);
         k++;
      end
      k = 0;
      do begin
         idle(1);
         k++;
      end while (pulse !== 1'h1 && k < 200);
   endtask
   task automatic t_defaults;
      mchk(pmc_pkg::PMC_NORMAL);
      rchk(5'h00, 16'h1000);
      rchk(5'h18, 16'h0800);
      rchk(5'h1f, 16'h0000);
      rchk(5'h05, 16'h0000);
   endtask
   task automatic t_save;
      i_st.wr(5'h1f, 16'h0400);
      idle(1);
      mchk(pmc_pkg::PMC_SAVE);
      chk({12'h0, rx, tx, ed, pll}, 16'h0007);
      @(posedge clk) energy <= 1'h1;
      idle(8);
      mchk(pmc_pkg::PMC_NORMAL);
      rchk(5'h19, 16'h0010);
      @(posedge clk) energy <= 1'h0;
      idle(8);
      mchk(pmc_pkg::PMC_SAVE);
      i_st.wr(5'h00, 16'h0000);
      idle(1);
      mchk(pmc_pkg::PMC_NORMAL);
      i_st.wr(5'h00, 16'h1000);
      i_st.wr(5'h1f, 16'h0000);
   endtask
   task automatic t_sleep;
      i_st.wr(5'h18, 16'h0000);
      idle(1);
      mchk(pmc_pkg::PMC_SLEEP);
      gap(n);
      chk(n[15:0], 16'h0014);
      i_st.wr(5'h1a, 16'h0001);
      gap(n);
      gap(n);
      chk(n[15:0], 16'h0032);
      i_st.wr(5'h10, 16'h0010);
      idle(1);
      mchk(pmc_pkg::PMC_SLEEP_NOPLL);
      rchk(5'h10, 16'h0010);
      rchk(5'h19, 16'h0003);
      rchk(5'h1a, 16'h0001);
      @(posedge clk) link <= 1'h1;
      idle(8);
      mchk(pmc_pkg::PMC_NORMAL);
      @(posedge clk) link <= 1'h0;
      idle(8);
      mchk(pmc_pkg::PMC_SLEEP_NOPLL);
   endtask
   task automatic t_pwrdn;
      i_st.wr(5'h1f, 16'h0400);
      i_st.wr(5'h00, 16'h1800);
      idle(1);
      mchk(pmc_pkg::PMC_PWRDN);
      rchk(5'h00, 16'h1800);
      i_st.wr(5'h11, 16'h0020);
      idle(1);
      mchk(pmc_pkg::PMC_DEEP);
      chk({15'h0, slow}, 16'h0001);
      rchk(5'h11, 16'h0020);
      i_st.wr(5'h11, 16'h0000);
      i_st.wr(5'h00, 16'h1000);
      idle(1);
      mchk(pmc_pkg::PMC_SLEEP_NOPLL);
      i_st.wr(5'h00, 16'h8000);
      idle(1);
      mchk(pmc_pkg::PMC_RESET);
      i_st.rd(5'h00, got);
      chk(got & 16'h8000, 16'h8000);
      idle(20);
      mchk(pmc_pkg::PMC_NORMAL);
      rchk(5'h00, 16'h1000);
      rchk(5'h18, 16'h0800);
   endtask
   task automatic t_two_writes;
      i_st.wr(5'h00, 16'h1800);
      i_st.wr(5'h00, 16'h8000);
      idle(1);
      chk({15'h0, core_rst}, 16'h0000);
      mchk(pmc_pkg::PMC_NORMAL);
      rchk(5'h00, 16'h1000);
      // a new strap level must be taken up by the second reset
      @(posedge clk) strap <= 1'h0;
      i_st.wr(5'h00, 16'h8000);
      idle(1);
      chk({15'h0, core_rst}, 16'h0001);
      idle(20);
      rchk(5'h00, 16'h0000);
      mchk(pmc_pkg::PMC_NORMAL);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      idle(24);
      t_defaults();
      t_save();
      t_sleep();
      t_pwrdn();
      t_two_writes();
      complete_run();
   end
endmodule

`default_nettype wire
